// File: rtl/glc_pkg.sv
// Package for the low-nibble pin configuration block: offsets, fields, defaults, carriers.
// Behaviour
// - A four-bit function select field at bits 15:12, pin 0 at bit 12, makes a pin a general purpose IO when its bit is clear.
// - A four-bit drive type field at bits 11:8, pin 0 at bit 8, selects push/pull when set and open-drain when clear.
// - A four-bit direction field at bits 7:4, pin 0 at bit 4, makes a pin an output when set and an input when clear.
// - The value field at bits 3:0 drives an output pin with the written value, and a read always returns the pin level.
// - A pin is a wake or interrupt source only while its direction bit makes it an input.
// - A pin raises wake events only if its bit in the wake enable and polarity register is also set.
// - The function select field defaults to the EEPROM image, else the programmed OTP value, else 0xF.
// - The drive type field defaults to the EEPROM image, else the programmed OTP value, else 0x0.
// - The direction field defaults to the EEPROM image, else the programmed OTP value, else 0x0, all inputs.
// - The value field defaults to the EEPROM image, else the programmed OTP value, else 0x0.
// - An input pin's value bit has no defined reset value.
// - A USB reset or light reset reloads each field from the last loaded image, or its fixed default if none exists.
// - While the reset guard is active, the resets it covers leave all four fields untouched.
// - A wake level select bit triggers on a low pin level when clear and on a high level when set.
// - A pin set to its alternate function never produces a wake event.
package glc_pkg;
   localparam int          NPIN          = 4;
   localparam logic [7:0]  ADDR_CFG      = 8'h18;
   localparam logic [7:0]  ADDR_WAKE     = 8'h20;
   localparam logic [7:0]  ADDR_STATUS   = 8'h24;
   localparam logic [7:0]  ADDR_MASK     = 8'h28;
   localparam logic [7:0]  ADDR_GUARD    = 8'h2C;
   localparam int          VAL_LSB       = 0;
   localparam int          DIR_LSB       = 4;
   localparam int          DRV_LSB       = 8;
   localparam int          FSEL_LSB      = 12;
   localparam int          WPOL_LSB      = 16;
   localparam logic [3:0]  FSEL_DEFAULT  = 4'hF;
   localparam logic [3:0]  DRV_DEFAULT   = 4'h0;
   localparam logic [3:0]  DIR_DEFAULT   = 4'h0;
   localparam logic [3:0]  VAL_DEFAULT   = 4'h0;
   localparam logic [31:0] ZERO_WORD     = 32'h0000_0000;

   typedef struct packed {
      logic [3:0] fsel;
      logic [3:0] drv;
      logic [3:0] dir;
      logic [3:0] val;
   } glc_cfg_t;

   localparam glc_cfg_t CFG_DEFAULT = '{FSEL_DEFAULT, DRV_DEFAULT, DIR_DEFAULT, VAL_DEFAULT};

   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } glc_bus_t;

   typedef struct packed {
      logic [3:0] out;
      logic [3:0] oe;
   } glc_pin_t;
endpackage

// File: rtl/glc_gpio.sv
// Low-nibble general purpose pin configuration, data, wake and interrupt logic.
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module glc_gpio (
   input  wire logic              clock,
   input  wire logic              reset_n,
   input  wire glc_pkg::glc_bus_t bus,
   output var  logic [31:0]       rdata,
   input  wire logic              usb_reset,
   input  wire logic              light_reset,
   input  wire logic              eeprom_present,
   input  wire logic              otp_programmed,
   input  wire glc_pkg::glc_cfg_t eeprom_image,
   input  wire glc_pkg::glc_cfg_t otp_image,
   input  wire logic              image_load,
   input  wire logic [3:0]        pin_in,
   output var  glc_pkg::glc_pin_t pin,
   output var  logic [3:0]        wake_event,
   output var  logic              irq
);
   import glc_pkg::*;

   typedef struct packed {
      // Live fields and the image that a bus-side reset reloads.
      glc_cfg_t    cfg;
      glc_cfg_t    image;
      // Wake, status and interrupt control.
      logic [3:0]  wake_source_enable;
      logic [3:0]  wake_level_select;
      logic        guard;
      logic [3:0]  status;
      logic [3:0]  mask;
      // Pin synchroniser stages and the filtered level.
      logic [3:0]  s1;
      logic [3:0]  s2;
      logic [3:0]  s3;
      logic [3:0]  level;
      // Registered outputs.
      logic [31:0] rdata;
      glc_pin_t    pin;
      logic [3:0]  wake;
      logic        irq;
   } glc_state_t;

   glc_state_t st_q;
   glc_state_t st_d;

   // Picks the power-up source in priority order: EEPROM, then programmed OTP, then fixed values.
   function automatic glc_cfg_t pick_image(input logic     ee,
                                           input logic     otp,
                                           input glc_cfg_t ee_img,
                                           input glc_cfg_t otp_img);
      glc_cfg_t c;
      c = CFG_DEFAULT;
      if (ee) begin
         c = ee_img;
      end else if (otp) begin
         c = otp_img;
      end
      return c;
   endfunction

   // The value field reads back the synchronised pin level, not the written value.
   function automatic logic [31:0] cfg_word(input glc_cfg_t   c,
                                            input logic [3:0] lvl);
      logic [31:0] w;
      w = ZERO_WORD;
      w[FSEL_LSB +: NPIN] = c.fsel;
      w[DRV_LSB  +: NPIN] = c.drv;
      w[DIR_LSB  +: NPIN] = c.dir;
      w[VAL_LSB  +: NPIN] = lvl;
      return w;
   endfunction

   // Address decode shared by the write and the read path.
   function automatic logic hit(input glc_bus_t   b,
                                input logic [7:0] a);
      logic h;
      h = (b.addr == a);
      return h;
   endfunction

   typedef struct packed {
      logic cfg;
      logic wake;
      logic status;
      logic mask;
      logic guard;
   } glc_wsel_t;

   // Write strobe split per register; unmapped addresses select nothing and so are ignored.
   function automatic glc_wsel_t write_select(input glc_bus_t b);
      glc_wsel_t s;
      s        = '0;
      s.cfg    = b.wr && hit(b, ADDR_CFG);
      s.wake   = b.wr && hit(b, ADDR_WAKE);
      s.status = b.wr && hit(b, ADDR_STATUS);
      s.mask   = b.wr && hit(b, ADDR_MASK);
      s.guard  = b.wr && hit(b, ADDR_GUARD);
      return s;
   endfunction

   // A bit of the level moves only when the second and third stages agree.
   function automatic logic [3:0] filter_level(input logic [3:0] mid,
                                               input logic [3:0] last,
                                               input logic [3:0] held);
      logic [3:0] f;
      f = held;
      for (int i = 0; i < NPIN; i++) begin
         if (mid[i] == last[i]) begin
            f[i] = last[i];
         end
      end
      return f;
   endfunction

   // A configuration write replaces all four fields at once.
   function automatic glc_cfg_t cfg_from_word(input logic [31:0] w);
      glc_cfg_t c;
      c.fsel = w[FSEL_LSB +: NPIN];
      c.drv  = w[DRV_LSB  +: NPIN];
      c.dir  = w[DIR_LSB  +: NPIN];
      c.val  = w[VAL_LSB  +: NPIN];
      return c;
   endfunction

   // A bus-side reset restores the last image unless the guard holds the fields.
   function automatic glc_cfg_t reload(input glc_cfg_t cur,
                                       input glc_cfg_t img,
                                       input logic     usb_rst,
                                       input logic     light_rst,
                                       input logic     grd);
      glc_cfg_t c;
      c = cur;
      if ((usb_rst || light_rst) && !grd) begin
         c = img;
      end
      return c;
   endfunction

   // A pin triggers only as a GPIO input sitting at its selected level.
   function automatic logic [3:0] trigger(input logic [3:0] lvl,
                                          input logic [3:0] pol,
                                          input glc_cfg_t   c);
      logic [3:0] match;
      logic [3:0] is_input;
      logic [3:0] is_gpio;
      logic [3:0] t;
      match    = ~(lvl ^ pol);
      is_input = ~c.dir;
      is_gpio  = ~c.fsel;
      t        = match & is_input & is_gpio;
      return t;
   endfunction

   // Sticky status: a one written clears, a live trigger sets, and the set wins a tie.
   function automatic logic [3:0] status_next(input logic [3:0] cur,
                                              input logic       clr_en,
                                              input logic [3:0] clr,
                                              input logic [3:0] set);
      logic [3:0] s;
      s = cur;
      if (clr_en) begin
         s = s & ~clr;
      end
      s = s | set;
      return s;
   endfunction

   // A trigger sets status even without the wake enable; only the wake output needs it.
   function automatic logic [3:0] wake_of(input logic [3:0] t,
                                          input logic [3:0] en);
      logic [3:0] w;
      w = t & en;
      return w;
   endfunction

   // The interrupt is a level that stays high while any unmasked status bit is set.
   function automatic logic irq_of(input logic [3:0] sts,
                                   input logic [3:0] msk);
      logic any;
      any = |(sts & msk);
      return any;
   endfunction

   // Open-drain drives only low; push/pull drives both levels.
   function automatic glc_pin_t drive_of(input glc_cfg_t c);
      glc_pin_t p;
      for (int i = 0; i < NPIN; i++) begin
         p.out[i] = c.drv[i] & c.val[i];
         p.oe[i]  = c.dir[i] & ~c.fsel[i] & (c.drv[i] | ~c.val[i]);
      end
      return p;
   endfunction

   // Enable and level select share one word, each at its own field position.
   function automatic logic [31:0] wake_word(input logic [3:0] en,
                                             input logic [3:0] pol);
      logic [31:0] w;
      w = ZERO_WORD;
      w[VAL_LSB  +: NPIN] = en;
      w[WPOL_LSB +: NPIN] = pol;
      return w;
   endfunction

   // Status, mask and guard all sit in the low bits of an otherwise zero word.
   function automatic logic [31:0] low_word(input logic [3:0] v);
      logic [31:0] w;
      w = ZERO_WORD;
      w[VAL_LSB +: NPIN] = v;
      return w;
   endfunction

   // Read data are zero outside a read cycle and for every unmapped address.
   function automatic logic [31:0] read_mux(input glc_bus_t   b,
                                            input glc_cfg_t   c,
                                            input logic [3:0] lvl,
                                            input logic [3:0] en,
                                            input logic [3:0] pol,
                                            input logic [3:0] sts,
                                            input logic [3:0] msk,
                                            input logic       grd);
      logic [31:0] w;
      w = ZERO_WORD;
      if (b.rd) begin
         if (hit(b, ADDR_CFG)) begin
            w = cfg_word(c, lvl);
         end else if (hit(b, ADDR_WAKE)) begin
            w = wake_word(en, pol);
         end else if (hit(b, ADDR_STATUS)) begin
            w = low_word(sts);
         end else if (hit(b, ADDR_MASK)) begin
            w = low_word(msk);
         end else if (hit(b, ADDR_GUARD)) begin
            w = low_word(4'(grd));
         end
      end
      return w;
   endfunction

   glc_wsel_t  wsel;
   logic [3:0] trig;

   always_comb begin
      st_d       = st_q;
      wsel       = write_select(bus);
      trig       = trigger(st_q.level, st_q.wake_level_select, st_q.cfg);

      // Only the second stage reads the first, so a metastable bit settles before it is used.
      st_d.s1    = pin_in;
      st_d.s2    = st_q.s1;
      st_d.s3    = st_q.s2;
      st_d.level = filter_level(st_q.s2, st_q.s3, st_q.level);

      // An image load fills the remembered image, and the live fields unless an unguarded reset in that cycle reloads the previous one.
      if (image_load) begin
         st_d.image = pick_image(eeprom_present, otp_programmed, eeprom_image, otp_image);
         st_d.cfg   = st_d.image;
      end
      st_d.cfg = reload(st_d.cfg, st_q.image, usb_reset, light_reset, st_q.guard);

      // Writes come last, so software wins over a reload in the same cycle.
      if (wsel.cfg) begin
         st_d.cfg = cfg_from_word(bus.wdata);
      end
      if (wsel.wake) begin
         st_d.wake_source_enable = bus.wdata[VAL_LSB  +: NPIN];
         st_d.wake_level_select  = bus.wdata[WPOL_LSB +: NPIN];
      end
      if (wsel.mask) begin
         st_d.mask = bus.wdata[VAL_LSB +: NPIN];
      end
      if (wsel.guard) begin
         st_d.guard = bus.wdata[VAL_LSB];
      end

      // Every output is computed here and registered, so each port comes from a flip-flop.
      st_d.status = status_next(st_q.status, wsel.status, bus.wdata[VAL_LSB +: NPIN], trig);
      st_d.wake   = wake_of(trig, st_q.wake_source_enable);
      st_d.irq    = irq_of(st_d.status, st_q.mask);
      st_d.pin    = drive_of(st_q.cfg);
      st_d.rdata  = read_mux(bus, st_q.cfg, st_q.level, st_q.wake_source_enable,
                             st_q.wake_level_select, st_q.status, st_q.mask, st_q.guard);
   end

   // Power-on reset takes the fixed defaults; the image starts from them until a load.
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         st_q       <= '0;
         st_q.cfg   <= CFG_DEFAULT;
         st_q.image <= CFG_DEFAULT;
      end else begin
         st_q <= st_d;
      end
   end

   assign rdata      = st_q.rdata;
   assign pin        = st_q.pin;
   assign wake_event = st_q.wake;
   assign irq        = st_q.irq;
endmodule
`default_nettype wire

// File: dv/glc_pins_model.sv
// Far-side circuitry on the four pins: optional external drivers and pull-ups.
`timescale 1ns/1ps
`default_nettype none
module glc_pins_model
   import glc_pkg::*;
(
   input  wire glc_pkg::glc_pin_t pin,
   input  wire logic [3:0]        ext_en,
   input  wire logic [3:0]        ext_val,
   output var  logic [3:0]        level
);
   // The device wins a clash; a line released by both the device and its external driver floats up to its pull-up.
   always_comb begin
      for (int i = 0; i < NPIN; i++) begin
         level[i] = pin.oe[i] ? pin.out[i] : (ext_en[i] ? ext_val[i] : 1'b1);
      end
   end
endmodule
`default_nettype wire

// File: dv/glc_gpio_asserts.sv
// Concurrent checks on the ports of the low-nibble pin configuration block.
`timescale 1ns/1ps
`default_nettype none
module glc_gpio_asserts
   import glc_pkg::*;
(
   input wire logic              clock,
   input wire logic              reset_n,
   input wire glc_pkg::glc_bus_t bus,
   input wire logic [31:0]       rdata,
   input wire logic              usb_reset,
   input wire logic              light_reset,
   input wire logic              eeprom_present,
   input wire logic              otp_programmed,
   input wire glc_pkg::glc_cfg_t eeprom_image,
   input wire glc_pkg::glc_cfg_t otp_image,
   input wire logic              image_load,
   input wire glc_pkg::glc_pin_t pin
);
   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);
   function automatic logic [3:0] oe_of(input glc_cfg_t c);
      return c.dir & ~c.fsel & (c.drv | ~c.val);
   endfunction
   sequence s_cfg_wr; bus.wr && bus.addr == ADDR_CFG; endsequence
   sequence s_quiet; !bus.wr && !usb_reset && !light_reset && !image_load; endsequence
   a_pin_enable: assert property (s_cfg_wr ##1 s_quiet |=> pin.oe == oe_of($past(bus.wdata[15:0], 2)))
      else $error("pin enable does not follow config write");
   a_pin_drive: assert property (s_cfg_wr ##1 s_quiet |=> pin.out == ($past(bus.wdata[11:8], 2) & $past(bus.wdata[3:0], 2)))
      else $error("pin drive value does not follow config write");
   a_load_image: assert property (image_load ##1 s_quiet |=> pin.oe == oe_of($past(eeprom_present, 2) ?
      $past(eeprom_image, 2) : $past(otp_programmed, 2) ? $past(otp_image, 2) : CFG_DEFAULT)) else $error("bad image load");
   a_rd_fields: assert property (s_cfg_wr ##1 s_quiet ##1 bus.rd && bus.addr == ADDR_CFG && !usb_reset && !light_reset
      |=> rdata[15:4] == $past(bus.wdata[15:4], 3)) else $error("config readback differs");
   a_rd_reserved: assert property (bus.rd && bus.addr == ADDR_CFG |=> rdata[31:16] == 16'h0000)
      else $error("reserved bits read nonzero");
   a_rdata_idle: assert property (!bus.rd |=> rdata == ZERO_WORD)
      else $error("read data outside read cycle");
   a_unmapped_zero: assert property (bus.rd && bus.addr > ADDR_GUARD |=> rdata == ZERO_WORD)
      else $error("unmapped read nonzero");
   a_cfg_hold: assert property (s_quiet ##1 s_quiet |=> $stable(pin.oe) && $stable(pin.out))
      else $error("pins changed without cause");
endmodule
`default_nettype wire

// File: dv/tb.sv
// Self-checking testbench for the low-nibble pin configuration block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin error_cnt++; $display("[ERR] %0t got %h want %h", $time, a, b); end end
module tb;
   import glc_pkg::*;
   logic        clock = 1'b0, reset_n = 1'b0, usb_reset = 1'b0, light_reset = 1'b0, image_load = 1'b0, eep = 1'b0, otp = 1'b0;
   glc_bus_t    bus = '0;
   glc_cfg_t    ee_img = '{4'h0, 4'hA, 4'h5, 4'h3}, otp_img = '{4'h1, 4'h2, 4'hC, 4'h0};
   glc_pin_t    pin;
   logic [31:0] rdata, rv;
   logic [3:0]  lvl, wake_event, ext_val = 4'h0, ext_en = 4'h0;
   logic        irq;
   int          error_cnt = 0, cmp_count = 0;
   glc_gpio i_glc_gpio (.clock(clock), .reset_n(reset_n), .bus(bus), .rdata(rdata), .usb_reset(usb_reset),
      .light_reset(light_reset), .eeprom_present(eep), .otp_programmed(otp), .eeprom_image(ee_img),
      .otp_image(otp_img), .image_load(image_load), .pin_in(lvl), .pin(pin), .wake_event(wake_event), .irq(irq));
   glc_pins_model i_glc_pins_model (.pin(pin), .ext_en(ext_en), .ext_val(ext_val), .level(lvl));
   always #20 clock = ~clock;
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock) bus <= '{a, d, 1'b1, 1'b0};
      @(posedge clock) bus.wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clock) bus <= '{a, 32'h0, 1'b0, 1'b1};
      @(posedge clock) bus.rd <= 1'b0;
      @(negedge clock) rv = rdata;
   endtask
   task automatic pulse(input int k);
      @(posedge clock) {image_load, usb_reset, light_reset} <= 3'(1 << k);
      @(posedge clock) {image_load, usb_reset, light_reset} <= 3'h0;
      repeat (2) @(posedge clock);
   endtask
   task automatic t_load;
      for (int k = 0; k < 3; k++) begin
         @(posedge clock) eep <= (k == 0);
         otp <= (k < 2);
         pulse(2);
         rd(ADDR_CFG);
         `CHK(rv[15:4], k == 0 ? 12'h0A5 : k == 1 ? 12'h12C : 12'hF00)
      end
   endtask
   task automatic t_drive;
      wr(ADDR_CFG, 32'hFFFF_0FF5);
      rd(ADDR_CFG);
      `CHK(rv[31:4], 28'h00000FF)
      repeat (6) @(posedge clock);
      `CHK(pin, 8'h5F)
      rd(ADDR_CFG);
      `CHK(rv, 32'h0000_0FF5)
      wr(ADDR_CFG, 32'h0000_00F5);
      repeat (6) @(posedge clock);
      rd(ADDR_CFG);
      `CHK({pin.oe, rv[3:0]}, 8'hA5)
   endtask
   task automatic t_wake;
      @(posedge clock) ext_en <= 4'hF;
      ext_val <= 4'h3;
      wr(ADDR_CFG, 32'h0);
      wr(ADDR_WAKE, 32'h000F_0003);
      wr(ADDR_MASK, 32'h1);
      repeat (6) @(posedge clock);
      `CHK({wake_event, irq}, 5'h07)
      @(posedge clock) ext_val <= 4'h0;
      repeat (6) @(posedge clock);
      wr(ADDR_STATUS, 32'hF);
      rd(ADDR_STATUS);
      `CHK({rv[3:0], wake_event, irq}, 9'h000)
      @(posedge clock) ext_val <= 4'hF;
      wr(ADDR_WAKE, 32'h000F_000F);
      wr(ADDR_CFG, 32'h0000_8111);
      repeat (6) @(posedge clock);
      `CHK(wake_event, 4'h6)
   endtask
   task automatic t_reset;
      wr(ADDR_CFG, 32'h0000_0FF0);
      pulse(0);
      rd(ADDR_CFG);
      `CHK(rv[15:4], 12'hF00)
      wr(ADDR_GUARD, 32'h1);
      wr(ADDR_CFG, 32'h0000_0FF0);
      pulse(1);
      rd(ADDR_CFG);
      `CHK(rv[15:4], 12'h0FF)
      rd(8'h40);
      `CHK(rv, 32'h0)
   endtask
   task automatic final_report;
      $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge clock);
      reset_n <= 1'b1;
      t_load;
      t_drive;
      t_wake;
      t_reset;
      final_report;
   end
   // The tests need well under a thousand cycles; this margin only catches a hang.
   initial begin
      #200us;
      error_cnt++;
      final_report;
   end
endmodule
bind glc_gpio glc_gpio_asserts i_glc_gpio_asserts (.clock(clock), .reset_n(reset_n), .bus(bus), .rdata(rdata),
   .usb_reset(usb_reset), .light_reset(light_reset), .eeprom_present(eeprom_present), .otp_programmed(otp_programmed),
   .eeprom_image(eeprom_image), .otp_image(otp_image), .image_load(image_load), .pin(pin));
`default_nettype wire
